// *** include/sequencer_defs.svh ***
`ifndef SEQUENCER_DEFS_SVH
`define SEQUENCER_DEFS_SVH

// =====================================================================
// clock
`define CLK_PERIOD_PS        4000

// =====================================================================
// serial-port addresses of the divider bytes
`define DIV_ADDR_W           5
`define DIV_ADDR_FIRST       5'h06
`define DIV_ADDR_LAST        5'h0B
`define DIV_BYTES            6

// =====================================================================
// divider reset values
`define REF_DIV_RESET        8'h00
`define FB_DIV_RESET         8'h00
`define SW_DIV_RESET         8'h00

// =====================================================================
// timing, in microseconds as given
`define READY_TIME_US        1000
`define SYNTH_SETTLE_US      500
`define RX_HOP_SETTLE_US     100

// =====================================================================
// divided clock output, half period in reference cycles
`define CLKOUT_HALF_CYCLES   16'h000F

`endif

// *** include/sequencer_pkg.sv ***
package sequencer_pkg;

    // =================================================================
    // startup states, one-hot
    typedef enum logic [2:0] {
        ST_HOLD  = 3'b001,
        ST_START = 3'b010,
        ST_READY = 3'b100
    } startup_state_t;

    // =================================================================
    // one divider set
    typedef struct packed {
        logic [7:0] refDiv;
        logic [7:0] fbDiv;
        logic [7:0] swDiv;
    } divider_set_t;

endpackage

// *** include/divider_if.sv ***
`timescale 1ns/10ps
`default_nettype none

// =====================================================================
// divider bank carrier
interface divider_if;
    import sequencer_pkg::*;
    logic                  clearAll;
    logic                  wrEn;
    logic [4:0]            wrAddr;
    logic [7:0]            wrData;
    logic                  pairSel;
    divider_set_t          activeSet;

    modport bank (input clearAll, input wrEn, input wrAddr, input wrData, input pairSel, output activeSet);
    modport ctrl (output clearAll, output wrEn, output wrAddr, output wrData, output pairSel, input activeSet);
endinterface

`default_nettype wire

// *** design/divider_bank.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "sequencer_defs.svh"

module divider_bank
    import sequencer_pkg::*;
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic reset_n,
    // carrier
    divider_if.bank   port
);

    logic [7:0]   divMem_r   [`DIV_BYTES];
    logic [7:0]   divMem_nxt [`DIV_BYTES];
    divider_set_t activeSet_r;
    divider_set_t activeSet_nxt;
    logic [4:0]   wrIndex;

    // =================================================================
    // next contents: clear, then byte write, then selected set readout
    always_comb begin
        wrIndex = port.wrAddr - `DIV_ADDR_FIRST;
        for (int i = 0; i < `DIV_BYTES; i++) begin
            divMem_nxt[i] = divMem_r[i];
        end
        if (port.clearAll) begin
            for (int i = 0; i < `DIV_BYTES; i += 3) begin
                divMem_nxt[i]     = `REF_DIV_RESET;
                divMem_nxt[i + 1] = `FB_DIV_RESET;
                divMem_nxt[i + 2] = `SW_DIV_RESET;
            end
        end else if (port.wrEn) begin
            divMem_nxt[wrIndex[2:0]] = port.wrData;
        end
        if (port.pairSel) begin
            activeSet_nxt = '{divMem_r[3], divMem_r[4], divMem_r[5]};
        end else begin
            activeSet_nxt = '{divMem_r[0], divMem_r[1], divMem_r[2]};
        end
    end

    // =================================================================
    // registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < `DIV_BYTES; i++) begin
                divMem_r[i] <= 8'h00;
            end
            activeSet_r <= '0;
        end else begin
            for (int i = 0; i < `DIV_BYTES; i++) begin
                divMem_r[i] <= divMem_nxt[i];
            end
            activeSet_r <= activeSet_nxt;
        end
    end

    assign port.activeSet = activeSet_r;

endmodule // divider_bank

`default_nettype wire

// *** design/transceiver_reset_startup_sequencer.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "sequencer_defs.svh"

module transceiver_reset_startup_sequencer
    import sequencer_pkg::*;
#(
    parameter int READY_CYCLES    = `READY_TIME_US * 1000000 / `CLK_PERIOD_PS,
    parameter int SYNTH_CYCLES    = `SYNTH_SETTLE_US * 1000000 / `CLK_PERIOD_PS,
    parameter int HOP_CYCLES      = `RX_HOP_SETTLE_US * 1000000 / `CLK_PERIOD_PS,
    parameter int CLKOUT_HALF     = `CLKOUT_HALF_CYCLES
) (
    // clock and power-on reset
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    // manual reset pin, high resets
    input  wire logic       manualResetPin,
    // serial-port write
    input  wire logic       spiWrite,
    input  wire logic [4:0] spiAddr,
    input  wire logic [7:0] spiData,
    input  wire logic       pairSelWrite,
    input  wire logic       pairSelValue,
    // mode
    input  wire logic       synthOn,
    input  wire logic       rxMode,
    // status and outputs
    output logic            deviceReady,
    output logic            clkOut,
    output logic            lockDetect,
    output logic [7:0]      activeRefDiv,
    output logic [7:0]      activeFbDiv,
    output logic [7:0]      activeSwDiv
);

    // =================================================================
    // parameter checks
    if (READY_CYCLES < 1 || SYNTH_CYCLES < 1 || HOP_CYCLES < 1) begin : gBadTime
        $error("settle and ready counts must be at least one cycle");
    end
    if (CLKOUT_HALF < 1 || CLKOUT_HALF > 65535) begin : gBadHalf
        $error("clock output half period out of range");
    end

    divider_if divBus ();

    // =================================================================
    // startup state
    startup_state_t state_r;
    startup_state_t state_nxt;
    logic [31:0]    readyCnt_r;
    logic [31:0]    readyCnt_nxt;

    // reset hold, then count until ready
    always_comb begin
        state_nxt    = state_r;
        readyCnt_nxt = readyCnt_r;
        case (state_r)
            ST_HOLD: begin
                readyCnt_nxt = 32'(READY_CYCLES);
                if (!manualResetPin) begin
                    state_nxt = ST_START;
                end
            end
            ST_START: begin
                if (readyCnt_r > 32'h00000001) begin
                    readyCnt_nxt = readyCnt_r - 32'h00000001;
                end else begin
                    readyCnt_nxt = 32'h00000000;
                    state_nxt    = ST_READY;
                end
            end
            ST_READY: begin
                readyCnt_nxt = 32'h00000000;
            end
            default: begin
                state_nxt    = ST_HOLD;
                readyCnt_nxt = 32'(READY_CYCLES);
            end
        endcase
        if (manualResetPin) begin
            state_nxt    = ST_HOLD;
            readyCnt_nxt = 32'(READY_CYCLES);
        end
    end

    // power-on reset starts the count directly
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r    <= ST_START;
            readyCnt_r <= 32'(READY_CYCLES);
        end else begin
            state_r    <= state_nxt;
            readyCnt_r <= readyCnt_nxt;
        end
    end

    assign deviceReady = (state_r == ST_READY);

    // =================================================================
    // divided clock output, silent until ready
    logic [15:0] clkCnt_r;
    logic [15:0] clkCnt_nxt;
    logic        clkOut_r;
    logic        clkOut_nxt;

    always_comb begin
        clkCnt_nxt = clkCnt_r;
        clkOut_nxt = clkOut_r;
        if (!deviceReady || manualResetPin) begin
            clkCnt_nxt = 16'h0000;
            clkOut_nxt = 1'b0;
        end else if (clkCnt_r >= 16'(CLKOUT_HALF - 1)) begin
            clkCnt_nxt = 16'h0000;
            clkOut_nxt = !clkOut_r;
        end else begin
            clkCnt_nxt = clkCnt_r + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            clkCnt_r <= 16'h0000;
            clkOut_r <= 1'b0;
        end else begin
            clkCnt_r <= clkCnt_nxt;
            clkOut_r <= clkOut_nxt;
        end
    end

    assign clkOut = clkOut_r;

    // =================================================================
    // serial writes, taken only once ready
    logic addrHit;
    logic pairSel_r;
    logic pairSel_nxt;

    assign addrHit = (spiAddr >= `DIV_ADDR_FIRST) && (spiAddr <= `DIV_ADDR_LAST);

    always_comb begin
        pairSel_nxt = pairSel_r;
        if (!deviceReady || manualResetPin) begin
            pairSel_nxt = 1'b0;
        end else if (pairSelWrite) begin
            pairSel_nxt = pairSelValue;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pairSel_r <= 1'b0;
        end else begin
            pairSel_r <= pairSel_nxt;
        end
    end

    // clear from the first edge the pin is seen high, not one edge later
    assign divBus.clearAll = (state_r == ST_HOLD) || manualResetPin;
    assign divBus.wrEn     = spiWrite && addrHit && deviceReady;
    assign divBus.wrAddr   = spiAddr;
    assign divBus.wrData   = spiData;
    assign divBus.pairSel  = pairSel_r;

    divider_bank uBank (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .port    (divBus.bank)
    );

    assign activeRefDiv = divBus.activeSet.refDiv;
    assign activeFbDiv  = divBus.activeSet.fbDiv;
    assign activeSwDiv  = divBus.activeSet.swDiv;

    // =================================================================
    // synthesizer lock indicator
    logic        synthOn_r;
    logic        lock_r;
    logic        lock_nxt;
    logic [31:0] lockCnt_r;
    logic [31:0] lockCnt_nxt;
    logic        hop;

    // a set change while receiving is a hop; a set change otherwise, or synthOn rising, is a full relock
    assign hop = pairSelWrite && deviceReady && (pairSelValue != pairSel_r);

    always_comb begin
        lock_nxt    = lock_r;
        lockCnt_nxt = lockCnt_r;
        if (!synthOn || !deviceReady || manualResetPin) begin
            lock_nxt    = 1'b0;
            lockCnt_nxt = 32'h00000000;
        end else if (!synthOn_r) begin
            lock_nxt    = 1'b0;
            lockCnt_nxt = 32'(SYNTH_CYCLES);
        end else if (hop) begin
            lock_nxt    = 1'b0;
            lockCnt_nxt = rxMode ? 32'(HOP_CYCLES) : 32'(SYNTH_CYCLES);
        end else if (lockCnt_r > 32'h00000001) begin
            lockCnt_nxt = lockCnt_r - 32'h00000001;
        end else begin
            lockCnt_nxt = 32'h00000000;
            lock_nxt    = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            synthOn_r <= 1'b0;
            lock_r    <= 1'b0;
            lockCnt_r <= 32'h00000000;
        end else begin
            synthOn_r <= synthOn && deviceReady;
            lock_r    <= lock_nxt;
            lockCnt_r <= lockCnt_nxt;
        end
    end

    assign lockDetect = lock_r;

endmodule // transceiver_reset_startup_sequencer

`default_nettype wire

// *** bench/transceiver_reset_startup_sequencer_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// port checker
module sequencer_assertions #(
    parameter int READY_CYCLES = 20,
    parameter int HOP_CYCLES   = 5,
    parameter int CLKOUT_HALF  = 4
) (
    // clock and resets
    input wire logic       ref_clk,
    input wire logic       reset_n,
    input wire logic       manualResetPin,
    // requests
    input wire logic       spiWrite,
    input wire logic [4:0] spiAddr,
    input wire logic [7:0] spiData,
    input wire logic       pairSelWrite,
    input wire logic       pairSelValue,
    input wire logic       synthOn,
    input wire logic       rxMode,
    // outputs
    input wire logic       deviceReady,
    input wire logic       clkOut,
    input wire logic       lockDetect,
    input wire logic [7:0] activeRefDiv,
    input wire logic [7:0] activeFbDiv,
    input wire logic [7:0] activeSwDiv
);
    localparam int RDY_MAX  = READY_CYCLES + 4;
    localparam int HOP_MAX  = HOP_CYCLES + 3;
    localparam int HALF_MAX = CLKOUT_HALF + 2;
    logic pairSel_r;
    logic pairSel_nxt;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // follow which set the host selected
    always_comb begin
        pairSel_nxt = pairSel_r;
        if (manualResetPin) pairSel_nxt = 1'b0;
        else if (pairSelWrite && deviceReady) pairSel_nxt = pairSelValue;
    end
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) pairSel_r <= 1'b0;
        else pairSel_r <= pairSel_nxt;
    end
    // a set change that should unlock the synthesizer
    sequence selTaken;
        pairSelWrite && deviceReady && synthOn && pairSelValue != pairSel_r;
    endsequence
    // accepted write of the first reference byte
    sequence refWrite;
        spiWrite && deviceReady && spiAddr == 5'h06 && !pairSel_r && !pairSelWrite && !manualResetPin;
    endsequence
    chk_hold_outputs: assert property (manualResetPin |=> !deviceReady && !clkOut && !lockDetect)
        else $error("outputs active while manual reset held");
    chk_hold_clears: assert property (manualResetPin [*2] |=> activeRefDiv == 8'h00 && activeFbDiv == 8'h00)
        else $error("dividers not cleared by manual reset");
    chk_ready_early: assert property ($fell(manualResetPin) |=> (!deviceReady) [*8])
        else $error("ready too soon after manual reset");
    chk_ready_late: assert property ($fell(manualResetPin) |-> ##[1:RDY_MAX] deviceReady)
        else $error("ready too late after manual reset");
    chk_clkout_idle: assert property (!deviceReady && !$past(deviceReady) |-> !clkOut)
        else $error("clock output active before ready");
    chk_clkout_start: assert property ($rose(deviceReady) |-> !clkOut ##[1:HALF_MAX] clkOut)
        else $error("clock output did not start");
    chk_write_lands: assert property (refWrite |-> ##2 activeRefDiv == $past(spiData, 2))
        else $error("divider byte not applied");
    chk_switch_unlock: assert property (selTaken |=> !lockDetect)
        else $error("lock held across set change");
    chk_hop_fast: assert property (selTaken ##0 rxMode |=> !lockDetect ##[1:HOP_MAX] lockDetect)
        else $error("receive hop settle too long");
    chk_full_settle: assert property (selTaken ##0 !rxMode |=> (!lockDetect) [*6])
        else $error("full settle too short");
endmodule // sequencer_assertions
`default_nettype wire

// *** bench/host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// host controller: reset pin and access gating
module host_model #(
    parameter int PULSE    = 25,
    parameter int POR_WAIT = 80,
    parameter int MAN_WAIT = 60
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic doReset,
    input wire logic clkOut,
    output logic     manualResetPin,
    output logic     hostOk
);
    // wait the fixed time or until the clock output moves
    task automatic settle(input int lim);
        logic last;
        int n;
        last = clkOut;
        n = 0;
        while (n < lim && clkOut === last) begin
            @(posedge ref_clk);
            n++;
        end
        #1 hostOk = 1'b1;
    endtask
    // pin undriven (pulled low) except during a manual pulse
    initial begin
        manualResetPin = 1'b0;
        hostOk = 1'b0;
        forever begin
            @(posedge ref_clk);
            if (doReset) begin
                #1 hostOk = 1'b0;
                manualResetPin = 1'b1;
                repeat (PULSE) @(posedge ref_clk);
                #1 manualResetPin = 1'b0;
                settle(MAN_WAIT);
            end else if (!hostOk && reset_n === 1'b1) begin
                settle(POR_WAIT);
            end
        end
    end
endmodule // host_model
`default_nettype wire

// *** bench/transceiver_reset_startup_sequencer_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
// =====================================================================
// bench top
module transceiver_reset_startup_sequencer_bench;
    import sequencer_pkg::*;
    localparam int HALF = 4;
    logic       ref_clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       spiWrite = 1'b0;
    logic       pairSelWrite = 1'b0;
    logic       pairSelValue = 1'b0;
    logic       synthOn = 1'b0;
    logic       rxMode = 1'b0;
    logic       doReset = 1'b0;
    logic [4:0] spiAddr = 5'h00;
    logic [7:0] spiData = 8'h00;
    logic       manualResetPin, hostOk, deviceReady, clkOut, lockDetect;
    logic [7:0] activeRefDiv, activeFbDiv, activeSwDiv;
    int         n_fail = 0;
    int         cmp_count = 0;
    transceiver_reset_startup_sequencer #(.READY_CYCLES(20), .SYNTH_CYCLES(10), .HOP_CYCLES(5),
        .CLKOUT_HALF(HALF)) i_dut (.ref_clk, .reset_n, .manualResetPin, .spiWrite, .spiAddr,
        .spiData, .pairSelWrite, .pairSelValue, .synthOn, .rxMode, .deviceReady, .clkOut,
        .lockDetect, .activeRefDiv, .activeFbDiv, .activeSwDiv);
    host_model i_host (.ref_clk, .reset_n, .doReset, .clkOut, .manualResetPin, .hostOk);
    always #2 ref_clk = ~ref_clk;
    task automatic step;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        spiAddr = a;
        spiData = d;
        spiWrite = 1'b1;
        step;
        spiWrite = 1'b0;
        step;
    endtask
    task automatic sel(input logic v);
        pairSelValue = v;
        pairSelWrite = 1'b1;
        step;
        pairSelWrite = 1'b0;
        step;
    endtask
    task automatic wait_host;
        int n;
        n = 0;
        while (hostOk !== 1'b1 && n < 500) begin
            step;
            n++;
        end
        if (hostOk !== 1'b1) n_fail++;
    endtask
    task automatic wait_lock(output int n);
        n = 0;
        step;
        while (lockDetect !== 1'b1 && n < 200) begin
            step;
            n++;
        end
        if (lockDetect !== 1'b1) n_fail++;
    endtask
    // ready after power-on, clock output toggles
    task automatic t_startup;
        logic c;
        wait_host;
        `CHK(deviceReady, 1'b1)
        c = clkOut;
        repeat (HALF) step;
        `CHK(clkOut, ~c)
    endtask
    // all six bytes and a refused address past the last byte, then both sets
    task automatic t_dividers;
        for (int i = 0; i < 7; i++) wr(5'h06 + 5'(i), 8'hA0 + 8'(i));
        step;
        `CHK({activeRefDiv, activeFbDiv, activeSwDiv}, 24'hA0A1A2)
        sel(1'b1);
        step;
        `CHK({activeRefDiv, activeFbDiv, activeSwDiv}, 24'hA3A4A5)
    endtask
    // full settle against receive hop settle
    task automatic t_settle;
        int nS;
        int nH;
        synthOn = 1'b1;
        wait_lock(nS);
        `CHK(lockDetect, 1'b1)
        sel(1'b0);
        wait_lock(nS);
        rxMode = 1'b1;
        sel(1'b1);
        wait_lock(nH);
        `CHK(nS > nH, 1'b1)
        `CHK(lockDetect, 1'b1)
        rxMode = 1'b0;
    endtask
    // manual pulse clears the device, writes refused while held
    task automatic t_manual;
        doReset = 1'b1;
        step;
        doReset = 1'b0;
        repeat (4) step;
        wr(5'h06, 8'hFF);
        `CHK({deviceReady, lockDetect, activeSwDiv}, 10'h000)
        wait_host;
        `CHK({deviceReady, activeRefDiv}, 9'h100)
    endtask
    task automatic tally_and_finish;
        $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        t_startup;
        t_dividers;
        t_settle;
        t_manual;
        tally_and_finish;
    end
    // watchdog
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_fail++;
        tally_and_finish;
    end
endmodule // transceiver_reset_startup_sequencer_bench
bind transceiver_reset_startup_sequencer sequencer_assertions #(.READY_CYCLES(READY_CYCLES),
    .HOP_CYCLES(HOP_CYCLES), .CLKOUT_HALF(CLKOUT_HALF)) i_chk (.ref_clk, .reset_n, .manualResetPin,
    .spiWrite, .spiAddr, .spiData, .pairSelWrite, .pairSelValue, .synthOn, .rxMode, .deviceReady,
    .clkOut, .lockDetect, .activeRefDiv, .activeFbDiv, .activeSwDiv);
`default_nettype wire
